// ### design/ctm_pkg.sv
// Constants, types and helpers of the CAN transceiver mode control block
// Operation
// - After power-up the transceiver starts in off mode, bus ignored.
// - Off mode selectable in every system mode; bus pins high impedance.
// - In off mode bus wake-up events are ignored, no wake indication.
// - Normal mode set by software, only in system normal or stop mode.
// - Normal and receive-only modes enable bus biasing at half supply.
// - Normal mode drives transmit level to bus; low is dominant.
// - Early low transmit ignored until a recessive level follows.
// - Resolved bus state appears as digital level on receive output.
// - Receive-only mode disables driver, keeps receive path working.
// - Receive-only mode set by software, only in system normal or stop.
// - Transceiver mode selected by dedicated software-written mode bits.
// - Wake-capable mode detects a bus wake-up pattern.
// - Transmit and receive path supports rates up to 2 Mbaud.
// - Wake-capable mode code is 01 and stays visible after wake-up.
// - After bus wake, receive output held low until mode changes or stop or fail-safe is entered.
// - Stuck dominant forces receive-only, flags failure, then resumes.
package ctm_pkg;
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned T_EN_NS = 20000;
	localparam int unsigned EN_CYC = (T_EN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned EN_W = $clog2(EN_CYC + 1);
	localparam int unsigned T_TXTO_US = 2000;
	localparam int unsigned TXTO_CYC = T_TXTO_US * CLK_MHZ;
	localparam int unsigned T_WAKE1_NS = 500;
	localparam int unsigned WAKE1_CYC = (T_WAKE1_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_WAKE2_US = 1800;
	localparam int unsigned WAKE2_CYC = T_WAKE2_US * CLK_MHZ;
	localparam int unsigned CNT_W = 16;

	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

	localparam int unsigned IRQ_WAKE = 0;
	localparam int unsigned IRQ_TXTO = 1;
	localparam int unsigned IRQ_REFUSED = 2;
	localparam int unsigned IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	localparam int unsigned STS_MODE = 0;
	localparam int unsigned STS_EFF = 2;
	localparam int unsigned STS_EN_DONE = 4;
	localparam int unsigned STS_WAKE = 5;
	localparam int unsigned STS_TXTO = 6;
	localparam int unsigned STS_ARMED = 7;

	typedef enum logic [1:0] {
		CTM_OFF = 2'b00,
		CTM_WAKE = 2'b01,
		CTM_RXO = 2'b10,
		CTM_NORM = 2'b11
	} ctm_mode_t;
	localparam ctm_mode_t MODE_RST = CTM_OFF;

	typedef enum logic [2:0] {
		SYS_INIT = 3'b000,
		SYS_NORMAL = 3'b001,
		SYS_STOP = 3'b010,
		SYS_SLEEP = 3'b011,
		SYS_RESTART = 3'b100,
		SYS_FAILSAFE = 3'b101
	} ctm_sys_t;

	function automatic logic ctm_tx_allowed(input logic [2:0] s);
		return (s == SYS_NORMAL) || (s == SYS_STOP);
	endfunction : ctm_tx_allowed

	function automatic logic ctm_hit(input logic [11:0] a,
		input logic [11:0] off);
		return a == off;
	endfunction : ctm_hit
endpackage : ctm_pkg

// ### design/ctm_tx_timeout.sv
// Dominant transmit time-out guard
`timescale 1ns/100ps
`default_nettype none
module ctm_tx_timeout
	import ctm_pkg::*;
#(
	parameter int unsigned TO_CYC = TXTO_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic normal_mode,
	input wire logic tx_dom,
	output logic to_active,
	output logic to_pulse
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic act;
		logic pulse;
	} ctm_to_st_t;

	ctm_to_st_t r, n;

	always_comb begin
		n = r;
		n.pulse = 1'b0;
		if (!normal_mode || !tx_dom) begin
			n.cnt = '0;
			n.act = 1'b0;
		end else if (!r.act) begin
			if (r.cnt == CNT_W'(TO_CYC - 1)) begin
				n.act = 1'b1;
				n.pulse = 1'b1;
			end else begin
				n.cnt = r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign to_active = r.act;
	assign to_pulse = r.pulse;

	a_txto_fire: assert property (@(posedge clk) disable iff (!rstn)
		normal_mode && tx_dom && !r.act && r.cnt == CNT_W'(TO_CYC - 1)
		|=> to_active && to_pulse)
		else $error("time-out did not fire at its count");
	a_txto_clear: assert property (@(posedge clk) disable iff (!rstn)
		to_active && !tx_dom |=> !to_active)
		else $error("time-out did not clear after release");
endmodule : ctm_tx_timeout
`default_nettype wire

// ### design/ctm_wake_det.sv
// Bus wake-up pattern detector
`timescale 1ns/100ps
`default_nettype none
module ctm_wake_det
	import ctm_pkg::*;
#(
	parameter int unsigned W2_CYC = WAKE2_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic bus_dom,
	output logic wake_pulse
);
	typedef enum logic [1:0] {
		WD_IDLE = 2'b00,
		WD_DOM1 = 2'b01,
		WD_REC = 2'b10,
		WD_DOM2 = 2'b11
	} ctm_wd_t;

	typedef struct packed {
		ctm_wd_t st;
		logic [CNT_W-1:0] cnt;
		logic pulse;
	} ctm_wd_st_t;

	ctm_wd_st_t r, n;
	logic in_win;

	// Phase length inside the legal window, counter saturates at upper bound
	assign in_win = (r.cnt >= CNT_W'(WAKE1_CYC)) && (r.cnt < CNT_W'(W2_CYC));

	always_comb begin
		n = r;
		n.pulse = 1'b0;
		if (r.cnt != CNT_W'(W2_CYC)) begin
			n.cnt = r.cnt + 1'b1;
		end
		if (!enable) begin
			n.st = WD_IDLE;
			n.cnt = '0;
		end else begin
			unique case (r.st)
				WD_IDLE: begin
					n.cnt = CNT_W'(1);
					if (bus_dom) n.st = WD_DOM1;
				end
				WD_DOM1: if (!bus_dom) begin
					n.cnt = CNT_W'(1);
					n.st = in_win ? WD_REC : WD_IDLE;
				end
				WD_REC: if (bus_dom) begin
					n.cnt = CNT_W'(1);
					n.st = in_win ? WD_DOM2 : WD_DOM1;
				end
				WD_DOM2: begin
					if (!bus_dom) begin
						n.st = WD_IDLE;
					end else if (r.cnt == CNT_W'(WAKE1_CYC)) begin
						n.st = WD_IDLE;
						n.pulse = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '{st: WD_IDLE, cnt: '0, pulse: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign wake_pulse = r.pulse;

	a_wake_cause: assert property (@(posedge clk) disable iff (!rstn)
		$rose(wake_pulse) |-> $past(r.st) == WD_DOM2 && $past(bus_dom))
		else $error("wake pulse without second dominant phase");
endmodule : ctm_wake_det
`default_nettype wire

// ### design/ctm_top.sv
// CAN transceiver mode control with APB registers
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ctm_top
	import ctm_pkg::*;
#(
	parameter int unsigned TO_CYC = TXTO_CYC,
	parameter int unsigned W2_CYC = WAKE2_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] sys_mode,
	input wire logic tx_line_in,
	input wire logic bus_dom_in,
	output logic rx_line_out,
	output logic drv_dominant,
	output logic drv_en,
	output logic bias_half_en,
	output logic bus_hiz,
	output logic wake_ind,
	output logic irq
);
	typedef struct packed {
		ctm_mode_t mode;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic [EN_W-1:0] en_cnt;
		logic en_done;
		logic tx_armed;
		logic wake_lat;
		logic [2:0] sys_q;
		logic rx_out;
		logic drv_dom;
		logic [31:0] rdata;
		logic err;
		logic [1:0] tx_sync;
		logic [1:0] bus_sync;
	} ctm_st_t;

	localparam ctm_st_t ST_RST = '{
		mode: MODE_RST, stat: IRQ_RST, mask: IRQ_RST, en_cnt: '0,
		en_done: 1'b0, tx_armed: 1'b0, wake_lat: 1'b0, sys_q: SYS_INIT,
		rx_out: 1'b1, drv_dom: 1'b0, rdata: RDATA_RST, err: 1'b0,
		tx_sync: 2'b11, bus_sync: 2'b00};

	logic [1:0] rst_q;
	logic rstn_s;
	ctm_st_t r, n;
	ctm_mode_t eff, req;
	logic tx_s, bus_s;
	logic to_active, to_pulse, wake_pulse;
	logic setup, wr, ctrl_wr, req_ok, rearm;
	logic [31:0] sts_word, rd_word;
	logic [IRQ_W-1:0] ev;

	// Reset enters asynchronously, leaves synchronously
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rstn_s = rst_q[1];

	// Both pins are asynchronous, so only the second sync stage is read
	assign tx_s = r.tx_sync[1];
	assign bus_s = r.bus_sync[1];

	assign eff = (r.mode == CTM_NORM && to_active) ? CTM_RXO : r.mode;

	ctm_tx_timeout #(
		.TO_CYC(TO_CYC)
	) u_txto (
		.clk(clk),
		.rstn(rstn_s),
		.normal_mode(r.mode == CTM_NORM),
		.tx_dom(!tx_s),
		.to_active(to_active),
		.to_pulse(to_pulse)
	);

	// detector runs only when wake-capable and not yet woken
	ctm_wake_det #(
		.W2_CYC(W2_CYC)
	) u_wake (
		.clk(clk),
		.rstn(rstn_s),
		.enable(r.mode == CTM_WAKE && !r.wake_lat),
		.bus_dom(bus_s),
		.wake_pulse(wake_pulse)
	);

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign ctrl_wr = wr && ctm_hit(paddr, ADDR_CTRL);
	assign req = ctm_mode_t'(pwdata[1:0]);
	// both bus modes gated by system mode
	assign req_ok = !req[1] || ctm_tx_allowed(sys_mode);
	// Entering stop or fail-safe rearms wake capability
	assign rearm = (sys_mode == SYS_STOP || sys_mode == SYS_FAILSAFE)
		&& sys_mode != r.sys_q;

	always_comb begin
		sts_word = '0;
		sts_word[STS_MODE +: 2] = r.mode;
		sts_word[STS_EFF +: 2] = eff;
		sts_word[STS_EN_DONE] = r.en_done;
		sts_word[STS_WAKE] = r.wake_lat;
		sts_word[STS_TXTO] = to_active;
		sts_word[STS_ARMED] = r.tx_armed;
	end

	always_comb begin
		rd_word = '0;
		if (ctm_hit(paddr, ADDR_CTRL)) begin
			rd_word[1:0] = r.mode;
		end else if (ctm_hit(paddr, ADDR_STATUS)) begin
			rd_word = sts_word;
		end else if (ctm_hit(paddr, ADDR_IRQ_STAT)) begin
			rd_word[IRQ_W-1:0] = r.stat;
		end else if (ctm_hit(paddr, ADDR_IRQ_MASK)) begin
			rd_word[IRQ_W-1:0] = r.mask;
		end
	end

	always_comb begin
		n = r;
		n.tx_sync = {r.tx_sync[0], tx_line_in};
		n.bus_sync = {r.bus_sync[0], bus_dom_in};
		n.sys_q = sys_mode;
		ev = '0;
		// a pulse still in flight as wake mode is left must not latch
		ev[IRQ_WAKE] = wake_pulse && r.mode == CTM_WAKE;
		ev[IRQ_TXTO] = to_pulse;

		// Read data captured in setup so it is stable in the access phase
		if (setup) begin
			n.rdata = pwrite ? RDATA_RST : rd_word;
			n.err = !(ctm_hit(paddr, ADDR_CTRL) || ctm_hit(paddr, ADDR_STATUS)
				|| ctm_hit(paddr, ADDR_IRQ_STAT)
				|| ctm_hit(paddr, ADDR_IRQ_MASK));
		end

		if (ctrl_wr) begin
			if (req_ok) begin
				n.mode = req;
			end else begin
				ev[IRQ_REFUSED] = 1'b1;
			end
		end
		if (wr && ctm_hit(paddr, ADDR_IRQ_MASK)) begin
			n.mask = pwdata[IRQ_W-1:0];
		end
		// Set wins over a write-one clear in the same cycle
		n.stat = r.stat;
		if (wr && ctm_hit(paddr, ADDR_IRQ_STAT)) begin
			n.stat = r.stat & ~pwdata[IRQ_W-1:0];
		end
		n.stat = n.stat | ev;

		// wake latch cleared only by a mode change or rearm
		if (ev[IRQ_WAKE]) begin
			n.wake_lat = 1'b1;
		end else if ((ctrl_wr && req_ok && req != r.mode) || rearm) begin
			n.wake_lat = 1'b0;
		end

		// Enabling delay restarts whenever normal mode is left
		if (r.mode != CTM_NORM) begin
			n.en_cnt = '0;
			n.en_done = 1'b0;
		end else if (!r.en_done) begin
			if (r.en_cnt == EN_W'(EN_CYC - 1)) begin
				n.en_done = 1'b1;
			end else begin
				n.en_cnt = r.en_cnt + 1'b1;
			end
		end

		// arm only after a recessive level once delay is over
		if (!r.en_done) begin
			n.tx_armed = 1'b0;
		end else if (tx_s) begin
			n.tx_armed = 1'b1;
		end

		// transmit level onto the output stage
		n.drv_dom = (eff == CTM_NORM) && r.tx_armed && !tx_s;

		// receive path kept in both bus modes
		unique case (eff)
			CTM_NORM, CTM_RXO: n.rx_out = !bus_s;
			CTM_WAKE: n.rx_out = !r.wake_lat;
			CTM_OFF: n.rx_out = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rstn_s) begin
		if (!rstn_s) begin
			r <= ST_RST;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.rdata;
	assign pslverr = r.err && psel && penable;
	assign pready = 1'b1;
	assign rx_line_out = r.rx_out;
	assign drv_dominant = r.drv_dom;
	// driver only in effective normal mode
	assign drv_en = (eff == CTM_NORM);
	// half-supply bias in both bus modes
	assign bias_half_en = (eff == CTM_NORM) || (eff == CTM_RXO);
	// pins high impedance in off mode
	assign bus_hiz = (r.mode == CTM_OFF);
	assign wake_ind = r.wake_lat;
	assign irq = |(r.stat & r.mask);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn_s);

	sequence s_late_low;
		r.mode == CTM_NORM && !to_active && $rose(r.en_done) && !tx_s;
	endsequence
	sequence s_held_low;
		!tx_s [*2];
	endsequence
	sequence s_to_fire;
		r.mode == CTM_NORM && to_pulse;
	endsequence

	a_reset_off: assert property ($rose(rstn_s) |-> r.mode == CTM_OFF)
		else $error("transceiver not off after reset");
	a_off_quiet: assert property (r.mode == CTM_OFF
		|-> bus_hiz && !drv_en && !bias_half_en)
		else $error("off mode drives or biases the bus");
	a_off_no_wake: assert property (r.mode == CTM_OFF
		&& !r.wake_lat |=> !wake_ind)
		else $error("wake indicated in off mode");
	a_mode_refused: assert property (ctrl_wr && req[1]
		&& !ctm_tx_allowed(sys_mode) |=> r.mode == $past(r.mode)
		&& r.stat[IRQ_REFUSED])
		else $error("refused mode request changed the mode");
	a_mode_taken: assert property (ctrl_wr && req_ok
		|=> r.mode == $past(req))
		else $error("permitted mode write not taken");
	a_bias_half: assert property ((r.mode == CTM_NORM
		|| r.mode == CTM_RXO) |-> bias_half_en && !bus_hiz)
		else $error("bias missing in a bus mode");
	a_tx_follow: assert property (eff == CTM_NORM && r.tx_armed
		&& !tx_s |=> drv_dominant)
		else $error("dominant transmit not driven");
	a_late_block: assert property (s_late_low ##0 s_held_low
		|=> !drv_dominant)
		else $error("early dominant passed after enabling delay");
	a_rx_follow: assert property ((eff == CTM_NORM || eff == CTM_RXO)
		|=> rx_line_out == !$past(bus_s))
		else $error("receive output does not follow the bus");
	a_rxo_nodrive: assert property (eff == CTM_RXO
		|-> !drv_en ##1 !drv_dominant)
		else $error("driver active in receive-only mode");
	a_wake_low: assert property (r.mode == CTM_WAKE && r.wake_lat
		&& !ctrl_wr |=> !rx_line_out && r.mode == CTM_WAKE)
		else $error("woken receive output not held low");
	a_txto_rxo: assert property (r.mode == CTM_NORM && to_active
		|-> !drv_en && bias_half_en)
		else $error("time-out did not force receive-only");

	// The flag follows the registered pulse, one edge after the fault
	a_txto_flag: assert property (s_to_fire
		|-> !drv_en ##1 r.stat[IRQ_TXTO])
		else $error("time-out failure flag not set");
	// Leaving normal mode must cost a fresh enabling delay
	a_en_restart: assert property (r.mode != CTM_NORM
		|=> !r.en_done && !drv_dominant)
		else $error("enabling delay survived leaving normal mode");
	a_no_early_tx: assert property (drv_dominant |-> r.en_done)
		else $error("dominant driven before the enabling delay");
	a_wake_set: assert property (wake_pulse && r.mode == CTM_WAKE
		|=> wake_ind && r.stat[IRQ_WAKE])
		else $error("bus wake not latched");
	// A late pulse after wake mode is left is dropped on purpose
	a_wake_only: assert property (r.mode != CTM_WAKE
		|=> !$rose(wake_ind))
		else $error("wake latched outside wake-capable mode");
	a_rx_off: assert property (r.mode == CTM_OFF |=> rx_line_out)
		else $error("receive output active in off mode");
endmodule : ctm_top
`default_nettype wire

// ### verification/ctm_ctrl_model.sv
// Behavioural protocol controller and bus seen by the mode control block
`timescale 1ns/100ps
`default_nettype none
module ctm_ctrl_model
	import ctm_pkg::*;
#(
	parameter int unsigned EN_WAIT = EN_CYC + 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic tx_req,
	input wire logic early,
	input wire logic drv_dominant,
	input wire logic wake_dom,
	output logic tx_line_in,
	output logic bus_dom_in
);
	int unsigned cnt_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 0;
		end else if (!en) begin
			cnt_r <= 0;
		end else if (cnt_r < EN_WAIT) begin
			cnt_r <= cnt_r + 1;
		end
	end

	// recessive until delay
	// Early low appears only when the bench injects that fault
	assign tx_line_in = !(early || (tx_req && cnt_r >= EN_WAIT));
	// Wired bus: any dominant source wins
	assign bus_dom_in = drv_dominant || wake_dom;
endmodule : ctm_ctrl_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the CAN transceiver mode control block
`timescale 1ns/100ps
`default_nettype none
module testbench
	import ctm_pkg::*;
();
	localparam int unsigned TO = 800;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] sys_mode;
	logic tx_line_in, bus_dom_in, rx_line_out, drv_dominant, drv_en;
	logic bias_half_en, bus_hiz, wake_ind, irq;
	logic en, tx_req, early, wake_dom;
	int mismatches, n_tests, cycles;

	ctm_top #(.TO_CYC(TO), .W2_CYC(200)) u_dut (.clk(clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_mode(sys_mode), .tx_line_in(tx_line_in),
		.bus_dom_in(bus_dom_in), .rx_line_out(rx_line_out),
		.drv_dominant(drv_dominant), .drv_en(drv_en),
		.bias_half_en(bias_half_en), .bus_hiz(bus_hiz),
		.wake_ind(wake_ind), .irq(irq));

	ctm_ctrl_model u_ctrl (.clk(clk), .rstn(rstn), .en(en),
		.tx_req(tx_req), .early(early), .drv_dominant(drv_dominant),
		.wake_dom(wake_dom), .tx_line_in(tx_line_in),
		.bus_dom_in(bus_dom_in));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// A hang counts as a mismatch and still reaches the report
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp, what);
	endtask : rdchk

	// Ends on a falling edge so pin checks see settled levels
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc

	task automatic wake_pat();
		@(posedge clk);
		wake_dom <= 1'b1;
		repeat (20) @(posedge clk);
		wake_dom <= 1'b0;
		repeat (20) @(posedge clk);
		wake_dom <= 1'b1;
		repeat (20) @(posedge clk);
		wake_dom <= 1'b0;
		cyc(8);
	endtask : wake_pat

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		sys_mode = SYS_NORMAL;
		en = 1'b0;
		tx_req = 1'b0;
		early = 1'b0;
		wake_dom = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		cyc(3);
		chk({bus_hiz, drv_en, bias_half_en, rx_line_out}, 4'h9, "rst pins");
		rdchk(ADDR_CTRL, 32'h0000_0000, "rst mode");
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk(err, 1'b1, "unmapped err");
		chk(rd, 32'h0000_0000, "unmapped data");
		wake_pat();
		chk(wake_ind, 1'b0, "off wake");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0000, "off wake irq");
		$display("test reset and off done");

		@(posedge clk);
		sys_mode <= SYS_SLEEP;
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		apb(1'b1, ADDR_CTRL, 32'h0000_0002);
		rdchk(ADDR_CTRL, 32'h0000_0000, "refused mode");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0004, "refused flag");
		chk(irq, 1'b0, "masked irq");
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
		cyc(2);
		chk(irq, 1'b1, "unmasked irq");
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0004);
		cyc(2);
		chk(irq, 1'b0, "cleared irq");
		$display("test refusal done");

		@(posedge clk);
		sys_mode <= SYS_STOP;
		apb(1'b1, ADDR_CTRL, 32'h0000_0002);
		wake_dom <= 1'b1;
		cyc(8);
		chk({drv_en, bias_half_en, bus_hiz}, 3'b010, "rxo pins");
		chk(rx_line_out, 1'b0, "rxo dominant");
		@(posedge clk);
		wake_dom <= 1'b0;
		cyc(8);
		chk(rx_line_out, 1'b1, "rxo recessive");
		$display("test receive only done");

		@(posedge clk);
		sys_mode <= SYS_NORMAL;
		apb(1'b1, ADDR_CTRL, 32'h0000_0003);
		en <= 1'b1;
		early <= 1'b1;
		cyc(EN_CYC + 20);
		chk(drv_dominant, 1'b0, "early low sent");
		rdchk(ADDR_STATUS, 32'h0000_001F, "not armed");
		early <= 1'b0;
		cyc(6);
		rdchk(ADDR_STATUS, 32'h0000_009F, "armed");
		tx_req <= 1'b1;
		cyc(10);
		chk({drv_dominant, drv_en, bias_half_en}, 3'h7, "dom");
		chk(rx_line_out, 1'b0, "dom rx");
		@(posedge clk);
		tx_req <= 1'b0;
		cyc(10);
		chk({drv_dominant, rx_line_out}, 2'b01, "recessive");
		$display("test normal done");

		@(posedge clk);
		tx_req <= 1'b1;
		cyc(TO + 10);
		chk({drv_en, drv_dominant, irq}, 3'b001, "tx time-out");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0002, "time-out flag");
		tx_req <= 1'b0;
		cyc(10);
		chk(drv_en, 1'b1, "resume normal");
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
		$display("test time-out done");

		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		en <= 1'b0;
		wake_pat();
		chk({wake_ind, rx_line_out, irq}, 3'b101, "woken");
		rdchk(ADDR_CTRL, 32'h0000_0001, "wake code");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0001, "wake flag");
		cyc(30);
		chk(rx_line_out, 1'b0, "rx held low");
		@(posedge clk);
		sys_mode <= SYS_STOP;
		cyc(3);
		chk({wake_ind, rx_line_out}, 2'b01, "rearmed");
		@(posedge clk);
		sys_mode <= SYS_SLEEP;
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		cyc(3);
		chk({rx_line_out, bus_hiz}, 2'b11, "off again");
		chk(wake_ind, 1'b0, "off wake clear");
		$display("test wake done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
